// ==== dv/ftcar_fabric_model.sv ====
// Fabric-side stand-in: six-byte frames on every channel, tx and recovered rx
`timescale 1ns/1ps
module ftcar_fabric_model (
    input  wire logic                       mclk,
    input  wire logic                       rst,
    input  wire logic                       parityEven,
    output ftcar_pkg::ftcar_txbyte_s [3:0]  fabricTx,
    output ftcar_pkg::ftcar_txbyte_s [3:0]  rxFramed
);
    import ftcar_pkg::*;
    logic [2:0]    idx;
    ftcar_txbyte_s b;
    ftcar_txbyte_s r;
    // ------------------------------------------------------------
    // Frame position and byte builder
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) idx <= 3'h0;
        else idx <= (idx == 3'h5) ? 3'h0 : idx + 3'h1;
    end
    // Last byte gets a wrong parity on purpose so the input check has work
    always_comb begin
        b = '0;
        b.data = (idx == 3'h0) ? 8'hF6 : (idx == 3'h1) ? 8'h28 : 8'h90 + {5'h0, idx};
        b.frameStart = (idx == 3'h0);
        b.isA1 = (idx == 3'h0);
        b.isA2 = (idx == 3'h1);
        b.isB1 = (idx == 3'h2);
        b.scrSkip = (idx < 3'h3);
        b.parity = (parityEven ? ^b.data : ~^b.data) ^ (idx == 3'h5);
        r = b;
        r.data = ~b.data; // Recovered bytes differ from tx so loopback is visible
        fabricTx = {4{b}};
        rxFramed = {4{r}};
    end
endmodule

// ==== dv/ftcar_regs_tb.sv ====
// Self-checking bench for the framer test control and alarm register group
`timescale 1ns/1ps
`include "ftcar_map.svh"
module ftcar_regs_tb;
    import ftcar_pkg::*;
    logic                mclk, rst, ce, loop, scr, pe, prevPe, prevLoop, monOn, parD;
    ftcar_busreq_s       busReq;
    logic [7:0]          busRdata, expD, rxD, prevKey;
    logic [1:0]          scrPos;
    ftcar_txbyte_s [3:0] fabricTx, rxFramed;
    ftcar_txout_s [3:0]  serTx, fabricRx;
    logic [3:0]          errCmd, active, parErr, rawAlarm, alarm, pairEn;
    ftcar_txbyte_s       prevTx, prevRx, src;
    int                  err_total = 0, num_checks = 0, a1Hits = 0;
    ftcar_regs dut_u (.mclk(mclk), .rst(rst), .ce(ce), .busReq(busReq), .busRdata(busRdata),
        .fabricTx(fabricTx), .errInsertCmd(errCmd), .serTx(serTx), .errInsertActive(active),
        .fabricParityErr(parErr), .rxFramed(rxFramed), .fabricRx(fabricRx),
        .backplaneLoopback(loop), .scrambleEnable(scr), .parityEven(pe),
        .quadAAlarmRaw(rawAlarm), .quadAAlarm(alarm), .pairAlarmEnable(pairEn));
    ftcar_fabric_model model_u (.mclk(mclk), .rst(rst), .parityEven(pe),
        .fabricTx(fabricTx), .rxFramed(rxFramed));
    // ------------------------------------------------------------
    // Clock, tasks and watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe; the next call waits an edge so strobes never merge
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq.wr <= 1'b0;
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] exp);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        @(negedge mclk);
        chk(busRdata, exp);
    endtask
    // Write then read with no gap, so the back-to-back port timing gets exercised
    task automatic wrrd(input logic [19:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge mclk);
        busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        busReq.rd <= 1'b0;
        @(negedge mclk);
        chk(busRdata, exp);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        results();
    end
    // Track what the design saw at each edge, and the scrambler key it owes that byte
    // Key bytes of x^7+x^6+1 seeded all ones; the model has three scrambled bytes a frame
    always @(posedge mclk) begin
        prevTx   <= fabricTx[0];
        prevRx   <= rxFramed[0];
        prevPe   <= pe;
        prevLoop <= loop;
        prevKey  <= (!scr || fabricTx[0].scrSkip) ? 8'h00 :
                    (scrPos == 2'h0) ? 8'hFE : (scrPos == 2'h1) ? 8'h04 : 8'h18;
        scrPos   <= fabricTx[0].scrSkip ? 2'h0 : scrPos + 2'h1;
    end
    // Looped bytes bypass the transmit scrambler; receive is descrambled whenever scrambling is on, looped or not
    always @(negedge mclk) if (monOn) begin
        src  = prevLoop ? prevRx : prevTx;
        expD = src.data;
        if (src.isA1 && active[0]) expD = 8'h5A;
        if (src.isA2 && active[0]) expD = 8'hC3;
        if (src.isB1) expD = src.data ^ 8'h81;
        if (!prevLoop) expD = expD ^ prevKey;
        if (src.isA1 && active[0] && serTx[0].data === 8'h5A) a1Hits++;
        rxD  = prevRx.data ^ prevKey;
        parD = prevTx.parity ^ (prevPe ? ^prevTx.data : ~^prevTx.data);
        chk(serTx[0].data, expD);
        chk({7'h0, serTx[0].parity}, {7'h0, prevPe ? ^expD : ~^expD});
        chk({7'h0, parErr[0]}, {7'h0, parD});
        chk(fabricRx[0].data, rxD);
        chk({7'h0, fabricRx[0].parity}, {7'h0, prevPe ? ^rxD : ~^rxD});
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        busReq = '0;
        errCmd = 4'h0;
        rawAlarm = 4'h0;
        monOn = 1'b0;
        ce = 1'b1;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(`FTCAR_OFF_CTRL, 8'h60);
        rd(`FTCAR_OFF_A1VAL, 8'h00);
        rd(`FTCAR_OFF_A2VAL, 8'h00);
        rd(`FTCAR_OFF_B1MASK, 8'h00);
        rd(`FTCAR_OFF_ALARM, 8'h00);
        rd(`FTCAR_OFF_PAIREN, 8'h00);
        rd(20'h30012, 8'h00);
        wr(`FTCAR_OFF_CTRL, 8'hFF);
        rd(`FTCAR_OFF_CTRL, 8'h7F);
        chk({5'h0, loop, pe, scr}, 8'h07);
        wrrd(`FTCAR_OFF_PAIREN, 8'hFF, 8'h0F);
        wr(`FTCAR_OFF_ALARM, 8'hFF);
        rd(`FTCAR_OFF_ALARM, 8'h00);
        wr(`FTCAR_OFF_PAIREN, 8'h05);
        rawAlarm <= 4'hF;
        repeat (2) @(negedge mclk);
        chk({4'h0, alarm}, 8'h05);
        chk({4'h0, pairEn}, 8'h05);
        rd(`FTCAR_OFF_ALARM, 8'h05);
        rawAlarm <= 4'h0;
        wrrd(`FTCAR_OFF_A1VAL, 8'h5A, 8'h5A);
        wr(`FTCAR_OFF_A2VAL, 8'hC3);
        wr(`FTCAR_OFF_B1MASK, 8'h81);
        rd(`FTCAR_OFF_A2VAL, 8'hC3);
        // Clock enable low freezes the registers, so this write must be lost
        ce <= 1'b0;
        wr(`FTCAR_OFF_A2VAL, 8'h11);
        ce <= 1'b1;
        rd(`FTCAR_OFF_A2VAL, 8'hC3);
        wr(`FTCAR_OFF_CTRL, 8'h22);
        monOn <= 1'b1;
        @(posedge mclk);
        errCmd <= 4'hF;
        repeat (36) @(posedge mclk);
        chk(a1Hits[7:0], 8'h02);
        errCmd <= 4'h0;
        wr(`FTCAR_OFF_CTRL, 8'h02);
        repeat (12) @(posedge mclk);
        // Scrambling on before loopback: leaving loopback would skew the key phase
        wr(`FTCAR_OFF_CTRL, 8'h62);
        repeat (12) @(posedge mclk);
        wr(`FTCAR_OFF_CTRL, 8'h12);
        repeat (12) @(posedge mclk);
        monOn <= 1'b0;
        results();
    end
endmodule

// ==== rtl/ftcar_frame_corrupt.sv ====
// One channel path: framing byte corruption, B1 masking, scrambling and parity
`timescale 1ns/1ps
module ftcar_frame_corrupt (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  ce,
    input  wire ftcar_pkg::ftcar_txbyte_s txIn,
    input  wire logic                  insertCmd,
    input  wire ftcar_pkg::ftcar_ctrl_s   ctrl,
    input  wire logic [7:0]            a1Value,
    input  wire logic [7:0]            a2Value,
    input  wire logic [7:0]            b1Mask,
    output ftcar_pkg::ftcar_txout_s    txOut,
    output logic                       corrupting
);
    import ftcar_pkg::*;

    ftcar_corr_s st;
    ftcar_corr_s next_st;
    logic [3:0]  frameCnt;
    logic [7:0]  outByte;
    logic [14:0] scr;

    // ------------------------------------------------------------
    // Frame-synchronous scrambler, x^7 + x^6 + 1, eight bits per byte
    // ------------------------------------------------------------
    function automatic logic [14:0] scrByte(input logic [6:0] seed);
        logic [6:0] s;
        logic [7:0] key;
        s   = seed;
        key = `FTCAR_BYTE_RST;
        for (int i = 0; i < `FTCAR_SCR_STEPS; i++) begin
            key[7 - i] = s[6];
            s          = {s[5:0], s[6] ^ s[5]};
        end
        return {s, key};
    endfunction

    // Next state: run counter, substitution, masking, scrambling, parity
    always_comb begin
        next_st  = st;
        frameCnt = st.cnt;
        scr      = scrByte(st.lfsr);
        outByte  = txIn.data;
        if (txIn.frameStart) begin
            if (st.pending) begin
                frameCnt        = ctrl.runLen;
                next_st.pending = 1'b0;
            end else if (st.cnt != `FTCAR_CNT_ZERO) begin
                frameCnt = st.cnt - `FTCAR_CNT_ONE;
            end
        end
        // A new command edge re-arms pending even when the load above clears it; the counter load still happens
        if (insertCmd && !st.prevCmd) begin
            next_st.pending = 1'b1;
        end
        next_st.prevCmd = insertCmd;
        next_st.cnt     = frameCnt;
        next_st.active  = (frameCnt != `FTCAR_CNT_ZERO);
        if (frameCnt != `FTCAR_CNT_ZERO && txIn.isA1) begin
            outByte = a1Value;
        end else if (frameCnt != `FTCAR_CNT_ZERO && txIn.isA2) begin
            outByte = a2Value;
        end
        if (txIn.isB1) begin
            outByte = outByte ^ b1Mask;
        end
        // Unscrambled first-row bytes re-seed, so the key lines up each frame
        if (txIn.scrSkip) begin
            next_st.lfsr = `FTCAR_SCR_SEED;
        end else begin
            next_st.lfsr = scr[14:8];
            if (ctrl.scramble) begin
                outByte = outByte ^ scr[7:0];
            end
        end
        next_st.out.data   = outByte;
        next_st.out.parity = ctrl.parityEven ? ^outByte : ~^outByte;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign txOut      = st.out;
    assign corrupting = st.active;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_a1_subst: assert property (
        (ce && txIn.isA1 && txIn.scrSkip && !txIn.isB1) |=>
        (corrupting ? (txOut.data == $past(a1Value)) : (txOut.data == $past(txIn.data))))
        else $error("A1 byte not substituted as expected");
    chk_b1_invert: assert property (
        (ce && txIn.isB1 && txIn.scrSkip && !txIn.isA1 && !txIn.isA2) |=>
        (txOut.data == ($past(txIn.data) ^ $past(b1Mask))))
        else $error("B1 mask not applied");
    chk_out_parity: assert property (
        $past(ce) |-> (txOut.parity == ($past(ctrl.parityEven) ? ^txOut.data : ~^txOut.data)))
        else $error("Output parity has wrong sense");
    chk_run_zero: assert property (
        (ce && txIn.frameStart && st.pending && ctrl.runLen == `FTCAR_CNT_ZERO) |=> !corrupting)
        else $error("Zero run length still corrupts");
    cov_run: cover property (ce && txIn.frameStart && st.pending && ctrl.runLen != '0);
endmodule

// ==== rtl/ftcar_map.svh ====
// Named offsets, reset values, field positions and counts of the framer test/alarm block
`ifndef FTCAR_MAP_SVH
`define FTCAR_MAP_SVH

// ------------------------------------------------------------
// Register port geometry
// ------------------------------------------------------------
`define FTCAR_ADDR_W        20
`define FTCAR_DATA_W        8
`define FTCAR_NUM_CH        4

// ------------------------------------------------------------
// Register offsets (absolute addresses on the register port)
// ------------------------------------------------------------
`define FTCAR_OFF_CTRL      20'h3000C
`define FTCAR_OFF_A1VAL     20'h3000D
`define FTCAR_OFF_A2VAL     20'h3000E
`define FTCAR_OFF_B1MASK    20'h3000F
`define FTCAR_OFF_ALARM     20'h30010
`define FTCAR_OFF_PAIREN    20'h30011

// ------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------
`define FTCAR_CTRL_RST      7'h60
`define FTCAR_BYTE_RST      8'h00
`define FTCAR_NIB_RST       4'h0
`define FTCAR_PAD_NIB       4'h0
`define FTCAR_PAD_BIT       1'b0
`define FTCAR_CTRL_LOOP_BIT 4
`define FTCAR_CTRL_PAR_BIT  5
`define FTCAR_CTRL_SCR_BIT  6

// ------------------------------------------------------------
// Counts and scrambler seed
// ------------------------------------------------------------
`define FTCAR_CNT_ZERO      4'h0
`define FTCAR_CNT_ONE       4'h1
`define FTCAR_SCR_SEED      7'h7F
`define FTCAR_SCR_STEPS     8

`endif

// ==== rtl/ftcar_pkg.sv ====
// Types shared by the framer test control and alarm register block
package ftcar_pkg;
    `include "ftcar_map.svh"

    // ------------------------------------------------------------
    // Register port request
    // ------------------------------------------------------------
    typedef struct packed {
        logic [`FTCAR_ADDR_W-1:0] addr;
        logic [7:0]               wdata;
        logic                     wr;
        logic                     rd;
    } ftcar_busreq_s;

    // ------------------------------------------------------------
    // Control register fields, MSB first
    // ------------------------------------------------------------
    typedef struct packed {
        logic       scramble;
        logic       parityEven;
        logic       loopback;
        logic [3:0] runLen;
    } ftcar_ctrl_s;

    // ------------------------------------------------------------
    // Byte stream with overhead markers, and parity-carrying output
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic       parity;
        logic       frameStart;
        logic       isA1;
        logic       isA2;
        logic       isB1;
        logic       scrSkip;
    } ftcar_txbyte_s;

    typedef struct packed {
        logic [7:0] data;
        logic       parity;
    } ftcar_txout_s;

    // ------------------------------------------------------------
    // State of one channel path
    // ------------------------------------------------------------
    typedef struct packed {
        logic         prevCmd;
        logic         pending;
        logic [3:0]   cnt;
        logic [6:0]   lfsr;
        logic         active;
        ftcar_txout_s out;
    } ftcar_corr_s;

    // ------------------------------------------------------------
    // State of the register block
    // ------------------------------------------------------------
    typedef struct packed {
        ftcar_ctrl_s ctrl;
        logic [7:0]  a1Val;
        logic [7:0]  a2Val;
        logic [7:0]  b1Mask;
        logic [3:0]  pairEn;
        logic [3:0]  alarm;
        logic [3:0]  parErr;
        logic [7:0]  rdata;
    } ftcar_state_s;
endpackage

// ==== rtl/ftcar_regs.sv ====
// Global test control and alarm register group with per-channel datapath hooks
`timescale 1ns/1ps
module ftcar_regs (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire ftcar_pkg::ftcar_busreq_s      busReq,
    output logic [7:0]                         busRdata,
    input  wire ftcar_pkg::ftcar_txbyte_s [3:0] fabricTx,
    input  wire logic [3:0]                    errInsertCmd,
    output ftcar_pkg::ftcar_txout_s [3:0]      serTx,
    output logic [3:0]                         errInsertActive,
    output logic [3:0]                         fabricParityErr,
    input  wire ftcar_pkg::ftcar_txbyte_s [3:0] rxFramed,
    output ftcar_pkg::ftcar_txout_s [3:0]      fabricRx,
    output logic                               backplaneLoopback,
    output logic                               scrambleEnable,
    output logic                               parityEven,
    input  wire logic [3:0]                    quadAAlarmRaw,
    output logic [3:0]                         quadAAlarm,
    output logic [3:0]                         pairAlarmEnable
);
    import ftcar_pkg::*;

    ftcar_state_s  st;
    ftcar_state_s  next_st;
    ftcar_txbyte_s [3:0] txSel;
    ftcar_txbyte_s [3:0] rxSel;
    logic [3:0]    parBad;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Full-width compare: aliases elsewhere in the map must not hit here
    function automatic logic regHit(input logic [`FTCAR_ADDR_W-1:0] addr,
                                    input logic [`FTCAR_ADDR_W-1:0] off);
        return (addr == off);
    endfunction

    // Read mux; unmapped addresses and unused bits answer zero
    function automatic logic [7:0] readValue(input logic [`FTCAR_ADDR_W-1:0] addr,
                                             input ftcar_state_s s);
        logic [7:0] v;
        v = `FTCAR_BYTE_RST;
        if (regHit(addr, `FTCAR_OFF_CTRL)) begin
            v = {`FTCAR_PAD_BIT, s.ctrl};
        end else if (regHit(addr, `FTCAR_OFF_A1VAL)) begin
            v = s.a1Val;
        end else if (regHit(addr, `FTCAR_OFF_A2VAL)) begin
            v = s.a2Val;
        end else if (regHit(addr, `FTCAR_OFF_B1MASK)) begin
            v = s.b1Mask;
        end else if (regHit(addr, `FTCAR_OFF_ALARM)) begin
            v = {`FTCAR_PAD_NIB, s.alarm};
        end else if (regHit(addr, `FTCAR_OFF_PAIREN)) begin
            v = {`FTCAR_PAD_NIB, s.pairEn};
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Register file and status next state
    // ------------------------------------------------------------
    // Writes to the alarm register are dropped: it only mirrors live state
    always_comb begin
        next_st = st;
        if (busReq.wr) begin
            if (regHit(busReq.addr, `FTCAR_OFF_CTRL)) begin
                next_st.ctrl = busReq.wdata[6:0];
            end
            if (regHit(busReq.addr, `FTCAR_OFF_A1VAL)) begin
                next_st.a1Val = busReq.wdata;
            end
            if (regHit(busReq.addr, `FTCAR_OFF_A2VAL)) begin
                next_st.a2Val = busReq.wdata;
            end
            if (regHit(busReq.addr, `FTCAR_OFF_B1MASK)) begin
                next_st.b1Mask = busReq.wdata;
            end
            if (regHit(busReq.addr, `FTCAR_OFF_PAIREN)) begin
                next_st.pairEn = busReq.wdata[3:0];
            end
        end
        // Read data stand for exactly one cycle after the strobe
        next_st.rdata  = busReq.rd ? readValue(busReq.addr, st) : `FTCAR_BYTE_RST;
        // Gated by the enable already in force; a same-cycle write acts next cycle
        next_st.alarm  = quadAAlarmRaw & st.pairEn;
        next_st.parErr = parBad;
    end

    // State register; clock enable low freezes everything
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st        <= '0;
            st.ctrl   <= `FTCAR_CTRL_RST;
            st.a1Val  <= `FTCAR_BYTE_RST;
            st.a2Val  <= `FTCAR_BYTE_RST;
            st.b1Mask <= `FTCAR_BYTE_RST;
            st.pairEn <= `FTCAR_NIB_RST;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Per-channel paths
    // ------------------------------------------------------------
    // Looped data are already scrambled on the line, so they bypass the
    // transmit scrambler; overhead substitution and B1 masking still apply
    generate
        for (genvar ch = 0; ch < `FTCAR_NUM_CH; ch++) begin : g_ch
            // Loopback mux in front of the serialiser path
            always_comb begin
                txSel[ch] = fabricTx[ch];
                if (st.ctrl.loopback) begin
                    txSel[ch]         = rxFramed[ch];
                    txSel[ch].scrSkip = 1'b1;
                end
                rxSel[ch]          = rxFramed[ch];
                rxSel[ch].isB1     = 1'b0;
                parBad[ch] = st.ctrl.parityEven ?
                             (^{fabricTx[ch].data, fabricTx[ch].parity}) :
                             (~^{fabricTx[ch].data, fabricTx[ch].parity});
            end

            ftcar_frame_corrupt u_tx (
                .mclk       (mclk),
                .rst        (rst),
                .ce         (ce),
                .txIn       (txSel[ch]),
                .insertCmd  (errInsertCmd[ch]),
                .ctrl       (st.ctrl),
                .a1Value    (st.a1Val),
                .a2Value    (st.a2Val),
                .b1Mask     (st.b1Mask),
                .txOut      (serTx[ch]),
                .corrupting (errInsertActive[ch])
            );

            // Same engine descrambles received data; no insertion on receive
            ftcar_frame_corrupt u_rx (
                .mclk       (mclk),
                .rst        (rst),
                .ce         (ce),
                .txIn       (rxSel[ch]),
                .insertCmd  (1'b0),
                .ctrl       (st.ctrl),
                .a1Value    (st.a1Val),
                .a2Value    (st.a2Val),
                .b1Mask     (`FTCAR_BYTE_RST),
                .txOut      (fabricRx[ch]),
                .corrupting ()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // All come straight from state flip-flops
    assign busRdata          = st.rdata;
    assign backplaneLoopback = st.ctrl.loopback;
    assign scrambleEnable    = st.ctrl.scramble;
    assign parityEven        = st.ctrl.parityEven;
    assign quadAAlarm        = st.alarm;
    assign pairAlarmEnable   = st.pairEn;
    assign fabricParityErr   = st.parErr;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    chk_a1_write_read: assert property (
        (ce && busReq.wr && busReq.addr == `FTCAR_OFF_A1VAL) ##1
        (ce && busReq.rd && busReq.addr == `FTCAR_OFF_A1VAL && !busReq.wr) |=>
        (busRdata == $past(busReq.wdata, 2)))
        else $error("A1 value read back differs from write");
    chk_a2_write: assert property (
        (ce && busReq.wr && busReq.addr == `FTCAR_OFF_A2VAL) |=>
        (st.a2Val == $past(busReq.wdata)))
        else $error("A2 value not stored");
    chk_mask_write: assert property (
        (ce && busReq.wr && busReq.addr == `FTCAR_OFF_B1MASK) |=>
        (st.b1Mask == $past(busReq.wdata)))
        else $error("B1 mask not stored");
    chk_loop_write: assert property (
        (ce && busReq.wr && busReq.addr == `FTCAR_OFF_CTRL) |=>
        (backplaneLoopback == $past(busReq.wdata[`FTCAR_CTRL_LOOP_BIT])))
        else $error("Loopback bit not taken from write");
    chk_scr_write: assert property (
        (ce && busReq.wr && busReq.addr == `FTCAR_OFF_CTRL) |=>
        (scrambleEnable == $past(busReq.wdata[`FTCAR_CTRL_SCR_BIT])) &&
        (parityEven == $past(busReq.wdata[`FTCAR_CTRL_PAR_BIT])))
        else $error("Scramble or parity bit not taken from write");
    chk_ctrl_upper: assert property (
        (ce && busReq.rd && busReq.addr == `FTCAR_OFF_CTRL) |=> !busRdata[7])
        else $error("Unused control bit reads one");
    chk_alarm_read: assert property (
        (ce && busReq.rd && busReq.addr == `FTCAR_OFF_ALARM) |=>
        (busRdata == {4'h0, $past(st.alarm)}))
        else $error("Alarm read value wrong");
    chk_alarm_gate: assert property (
        ce |=> (quadAAlarm == ($past(quadAAlarmRaw) & $past(pairAlarmEnable))))
        else $error("Alarm not gated by pair enable");
    chk_pair_write: assert property (
        (ce && busReq.wr && busReq.addr == `FTCAR_OFF_PAIREN) ##1
        (ce && busReq.rd && busReq.addr == `FTCAR_OFF_PAIREN && !busReq.wr) |=>
        (busRdata == {4'h0, $past(busReq.wdata[3:0], 2)}))
        else $error("Pair enable read back wrong");
    chk_idle_rdata: assert property (
        (ce && !busReq.rd) |=> (busRdata == 8'h00))
        else $error("Read data outside read answer");
    chk_unmapped_rd: assert property (
        (ce && busReq.rd && (busReq.addr < `FTCAR_OFF_CTRL ||
                             busReq.addr > `FTCAR_OFF_PAIREN)) |=> (busRdata == 8'h00))
        else $error("Unmapped read not zero");
    chk_in_parity: assert property (
        ce |=> (fabricParityErr[0] == ($past(parityEven) ?
                (^{$past(fabricTx[0].data), $past(fabricTx[0].parity)}) :
                (~^{$past(fabricTx[0].data), $past(fabricTx[0].parity)}))))
        else $error("Input parity check wrong");
    chk_insert_run: assert property (
        (errInsertActive[0] && ce && fabricTx[0].isA2 && fabricTx[0].scrSkip &&
         !fabricTx[0].frameStart && !backplaneLoopback && !fabricTx[0].isB1) |=>
        (serTx[0].data == $past(st.a2Val)))
        else $error("A2 byte not substituted during run");

    cov_loop_on:   cover property (ce && busReq.wr && busReq.addr == `FTCAR_OFF_CTRL &&
                                   busReq.wdata[`FTCAR_CTRL_LOOP_BIT]);
    cov_alarm:     cover property (quadAAlarm != 4'h0);
    cov_insert:    cover property (errInsertActive != 4'h0);
    cov_back2back: cover property (ce && busReq.wr ##1 ce && busReq.rd);
endmodule
